// >>> design/astx_slot_mapper.sv
// tx channel slot mapper: registers, sample crossing and per-pin slot output
`timescale 1ns/1ps
`default_nettype none
`include "astx_regs.svh"
module astx_slot_mapper
  import astx_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk, // register and sample clock
  input wire logic resetn, // async reset, low
  input wire logic [7:0] reg_addr, // register offset
  input wire logic reg_we, // write strobe
  input wire logic reg_re, // read strobe
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data
  input wire logic [1:0] fmt_sel, // tdm, i2s or lj framing
  input wire logic [1:0] slot_word_length, // slot length code
  input wire logic idle_cycle_fill, // 0 zero, 1 hi-z
  input wire logic smp_valid, // sample pair offered
  output logic smp_ready, // sample pair accepted
  input wire logic [31:0] smp_ch1, // channel 1 sample, msb aligned
  input wire logic [31:0] smp_ch2, // channel 2 sample, msb aligned
  input wire logic bit_clk, // link bit clock
  input wire logic frame_sync, // link frame sync
  output logic serial_out_primary, // primary data out
  output logic serial_out_primary_oe_n, // primary enable, low drives
  output logic serial_out_secondary, // secondary data out
  output logic serial_out_secondary_oe_n // secondary enable, low drives
);
  // ****************************************
  // register file
  // ****************************************
  logic [7:0] pin_sel_reg;
  logic [5:0] ch1_reg;
  logic [5:0] ch2_reg;

  // RQ7 reserved bits dropped on write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_sel_reg <= `ASTX_PIN_SEL_RST;
      ch1_reg <= 6'(`ASTX_CH1_RST);
      ch2_reg <= 6'(`ASTX_CH2_RST);
    end else if (reg_we) begin
      if (reg_addr == `ASTX_PIN_SEL_OFS) begin
        pin_sel_reg <= reg_wdata;
      end
      if (reg_addr == `ASTX_CH1_OFS) begin
        ch1_reg <= reg_wdata[5:0];
      end
      if (reg_addr == `ASTX_CH2_OFS) begin
        ch2_reg <= reg_wdata[5:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        `ASTX_PIN_SEL_OFS: reg_rdata <= pin_sel_reg;
        `ASTX_CH1_OFS: reg_rdata <= {2'h0, ch1_reg};
        `ASTX_CH2_OFS: reg_rdata <= {2'h0, ch2_reg};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // sample buffer and word crossing
  // ****************************************
  logic buf_valid;
  logic buf_ready;
  logic [63:0] buf_data;
  logic [63:0] hold_reg;
  logic req_reg;
  logic ack_m;
  logic ack_s;
  logic ack_reg;

  astx_pair_buf #(.W(64), .DEPTH(BUF_DEPTH)) u_buf (
    .clk(ref_clk),
    .rst_n(resetn),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data({smp_ch1, smp_ch2}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  assign buf_ready = (req_reg == ack_s);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_reg <= 64'h0;
      req_reg <= 1'b0;
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      ack_m <= ack_reg;
      ack_s <= ack_m;
      if (buf_valid && buf_ready) begin
        hold_reg <= buf_data;
        req_reg <= ~req_reg;
      end
    end
  end

  // ****************************************
  // configuration into the link domain
  // ****************************************
  localparam int CFGW = 25;
  logic [CFGW-1:0] cfg_bus;
  logic [CFGW-1:0] cfg_m;
  logic [CFGW-1:0] cfg_s;
  logic req_m;
  logic req_s;

  assign cfg_bus = {fmt_sel, idle_cycle_fill, slot_word_length, ch2_reg, ch1_reg, pin_sel_reg};

  always_ff @(posedge bit_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_m <= '0;
      cfg_s <= '0;
      req_m <= 1'b0;
      req_s <= 1'b0;
    end else begin
      cfg_m <= cfg_bus;
      cfg_s <= cfg_m;
      req_m <= req_reg;
      req_s <= req_m;
    end
  end

  logic [7:0] pin_s;
  logic [5:0] c1_s;
  logic [5:0] c2_s;
  astx_wlen_t wlen_s;
  logic fill_s;
  astx_fmt_t fmt_s;

  assign pin_s = cfg_s[7:0];
  assign c1_s = cfg_s[13:8];
  assign c2_s = cfg_s[19:14];
  assign wlen_s = astx_wlen_t'(cfg_s[21:20]);
  assign fill_s = cfg_s[22];
  assign fmt_s = astx_fmt_t'(cfg_s[24:23]);

  // ****************************************
  // frame position
  // ****************************************
  function automatic logic [4:0] last_bit(input astx_wlen_t w);
    unique case (w)
      wlen_16: last_bit = `ASTX_LAST_16;
      wlen_20: last_bit = `ASTX_LAST_20;
      wlen_24: last_bit = `ASTX_LAST_24;
      wlen_32: last_bit = `ASTX_LAST_32;
    endcase
  endfunction

  logic fs_q;
  logic fs_p;
  logic frame_ok_reg;
  logic [4:0] bit_reg;
  logic [4:0] slot_reg;
  logic frame_start;
  logic restart;
  logic right_half;
  logic [4:0] cur_bit;
  logic [4:0] cur_slot;

  assign frame_start = (fmt_s == fmt_i2s) ? (fs_p && !fs_q) : (fs_q && !fs_p);
  assign restart = (fmt_s == fmt_tdm) ? frame_start : (fs_q != fs_p);
  assign right_half = (fmt_s == fmt_i2s) ? fs_q : !fs_q;

  // RQ9 slot length from word length
  always_comb begin
    cur_bit = bit_reg + 5'h01;
    cur_slot = slot_reg;
    if (restart) begin
      cur_bit = 5'h00;
      cur_slot = 5'h00;
    end else if (bit_reg == last_bit(wlen_s)) begin
      cur_bit = 5'h00;
      cur_slot = slot_reg + 5'h01;
    end
  end

  always_ff @(posedge bit_clk or negedge resetn) begin
    if (!resetn) begin
      fs_q <= 1'b0;
      fs_p <= 1'b0;
      frame_ok_reg <= 1'b0;
      bit_reg <= 5'h00;
      slot_reg <= 5'h00;
    end else begin
      fs_q <= frame_sync;
      fs_p <= fs_q;
      bit_reg <= cur_bit;
      slot_reg <= cur_slot;
      if (frame_start) begin
        frame_ok_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // frame sample load
  // ****************************************
  logic [63:0] word_reg;
  logic [63:0] cur_word;
  logic load_now;

  assign load_now = frame_start && (req_s != ack_reg);
  assign cur_word = load_now ? hold_reg : word_reg;

  always_ff @(posedge bit_clk or negedge resetn) begin
    if (!resetn) begin
      word_reg <= 64'h0;
      ack_reg <= 1'b0;
    end else if (load_now) begin
      word_reg <= hold_reg;
      ack_reg <= req_s;
    end
  end

  // ****************************************
  // slot match and pin drive
  // ****************************************
  logic [4:0] eff_slot;
  logic slot_ok;
  logic hit1;
  logic hit2;
  logic b1;
  logic b2;
  logic [1:0] dout_reg;
  logic [1:0] oen_reg;

  // RQ4 RQ5 tdm uses slot, i2s/lj maps upper half right
  always_comb begin
    eff_slot = cur_slot;
    slot_ok = frame_ok_reg || frame_start;
    if (fmt_s != fmt_tdm) begin
      eff_slot = {right_half, cur_slot[3:0]};
      slot_ok = slot_ok && !cur_slot[4];
    end
  end

  // RQ4 RQ6 slot field compare
  assign hit1 = slot_ok && (eff_slot == c1_s[`ASTX_SLOT_MSB:0]);
  assign hit2 = slot_ok && (eff_slot == c2_s[`ASTX_SLOT_MSB:0]);
  assign b1 = cur_word[63 - 32'(cur_bit)];
  assign b2 = cur_word[31 - 32'(cur_bit)];

  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic on1;
    logic on2;
    // RQ1 select bit picks pin
    assign on1 = hit1 && (pin_s[`ASTX_CH1_PIN_BIT] == 1'(p));
    assign on2 = hit2 && (pin_s[`ASTX_CH2_PIN_BIT] == 1'(p));
    always_ff @(posedge bit_clk or negedge resetn) begin
      if (!resetn) begin
        dout_reg[p] <= 1'b0;
        oen_reg[p] <= 1'b1;
      end else if (on1 && c1_s[`ASTX_EN_BIT]) begin
        // RQ10 channel 1 wins shared slot
        dout_reg[p] <= b1;
        oen_reg[p] <= 1'b0;
      end else if (on2 && c2_s[`ASTX_EN_BIT]) begin
        dout_reg[p] <= b2;
        oen_reg[p] <= 1'b0;
      end else if (on1 || on2) begin
        // RQ2 RQ3 disabled channel slot tri-stated
        dout_reg[p] <= 1'b0;
        oen_reg[p] <= 1'b1;
      end else begin
        // RQ8 unused cycle fill
        dout_reg[p] <= 1'b0;
        oen_reg[p] <= fill_s;
      end
    end
  end

  assign serial_out_primary = dout_reg[0];
  assign serial_out_primary_oe_n = oen_reg[0];
  assign serial_out_secondary = dout_reg[1];
  assign serial_out_secondary_oe_n = oen_reg[1];

  // ****************************************
  // checks
  // ****************************************
  logic en1;
  logic en2;
  assign en1 = c1_s[`ASTX_EN_BIT];
  assign en2 = c2_s[`ASTX_EN_BIT];

  property p_ch1_pin;
    @(posedge bit_clk) disable iff (!resetn)
    (hit1 && en1) |=> ($past(pin_s[0]) ? !serial_out_secondary_oe_n : !serial_out_primary_oe_n);
  endproperty
  a_ch1_pin: assert property (p_ch1_pin) else $error("ch1 not on chosen pin"); // RQ1

  property p_ch1_off;
    @(posedge bit_clk) disable iff (!resetn)
    (hit1 && !en1 && !pin_s[0] && !(hit2 && en2 && !pin_s[1])) |=> serial_out_primary_oe_n;
  endproperty
  a_ch1_off: assert property (p_ch1_off) else $error("disabled ch1 slot driven"); // RQ2

  property p_ch2_off;
    @(posedge bit_clk) disable iff (!resetn)
    (hit2 && !en2 && pin_s[1] && !(hit1 && en1 && pin_s[0])) |=> serial_out_secondary_oe_n;
  endproperty
  a_ch2_off: assert property (p_ch2_off) else $error("disabled ch2 slot driven"); // RQ3

  property p_ch1_tdm;
    @(posedge bit_clk) disable iff (!resetn)
    (fmt_s == fmt_tdm && hit1) |-> (cur_slot == c1_s[4:0]);
  endproperty
  a_ch1_tdm: assert property (p_ch1_tdm) else $error("ch1 tdm slot wrong"); // RQ4

  property p_ch1_right;
    @(posedge bit_clk) disable iff (!resetn)
    (fmt_s != fmt_tdm && hit1 && c1_s[4]) |-> (right_half && cur_slot == {1'b0, c1_s[3:0]});
  endproperty
  a_ch1_right: assert property (p_ch1_right) else $error("ch1 right slot wrong"); // RQ5

  property p_ch2_read;
    @(posedge ref_clk) disable iff (!resetn)
    (reg_re && reg_addr == `ASTX_CH2_OFS) |=> (reg_rdata == {2'h0, $past(ch2_reg)});
  endproperty
  a_ch2_read: assert property (p_ch2_read) else $error("ch2 readback wrong"); // RQ6

  property p_rsvd_zero;
    @(posedge ref_clk) disable iff (!resetn)
    (reg_re && reg_addr == `ASTX_CH1_OFS) ##1 1'b1 |-> (reg_rdata[7:6] == 2'h0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero"); // RQ7

  property p_fill;
    @(posedge bit_clk) disable iff (!resetn)
    (!hit1 && !hit2) |=> (serial_out_primary == 1'b0 && serial_out_primary_oe_n == $past(fill_s));
  endproperty
  a_fill: assert property (p_fill) else $error("unused cycle fill wrong"); // RQ8

  property p_slot_len;
    @(posedge bit_clk) disable iff (!resetn)
    (!restart && bit_reg == last_bit(wlen_s)) |-> (cur_bit == 5'h00 && cur_slot == slot_reg + 5'h01);
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot length wrong"); // RQ9

  property p_prio;
    @(posedge bit_clk) disable iff (!resetn)
    (hit1 && hit2 && en1 && en2 && !pin_s[0] && !pin_s[1]) |=> (serial_out_primary == $past(b1));
  endproperty
  a_prio: assert property (p_prio) else $error("ch1 lost shared slot"); // RQ10
endmodule
`default_nettype wire

// >>> design/astx_regs.svh
// register offsets, field positions, reset values and slot timing for the tx slot mapper
// Functional notes
// RQ1 - select bit routes channel to primary/secondary pin
// RQ2 - channel 1 disabled leaves its slot tri-stated
// RQ3 - channel 2 disabled leaves its slot tri-stated
// RQ4 - channel 1 slot field places sample, resets 0
// RQ5 - values 16-31 map to right half in i2s/lj
// RQ6 - channel 2 slot field, same encoding, resets 1
// RQ7 - software writes zero to bits 7:6
// RQ8 - unused cycles drive zero or hi-z per fill
// RQ9 - word length field sets 16/20/24/32 bit slots
// RQ10 - lower channel wins on shared slot and pin
`ifndef ASTX_REGS_SVH
`define ASTX_REGS_SVH

`define ASTX_PIN_SEL_OFS 8'h1d
`define ASTX_CH1_OFS 8'h1e
`define ASTX_CH2_OFS 8'h1f
`define ASTX_PIN_SEL_RST 8'h00
`define ASTX_CH1_RST 8'h20
`define ASTX_CH2_RST 8'h21
`define ASTX_EN_BIT 5
`define ASTX_SLOT_MSB 4
`define ASTX_CH1_PIN_BIT 0
`define ASTX_CH2_PIN_BIT 1
`define ASTX_LAST_16 5'h0f
`define ASTX_LAST_20 5'h13
`define ASTX_LAST_24 5'h17
`define ASTX_LAST_32 5'h1f

`endif

// >>> design/astx_pkg.sv
// types shared by the tx slot mapper
package astx_pkg;
  typedef enum logic [1:0] {
    fmt_tdm = 2'h0,
    fmt_i2s = 2'h1,
    fmt_lj = 2'h3
  } astx_fmt_t;
  typedef enum logic [1:0] {
    wlen_16 = 2'h0,
    wlen_20 = 2'h1,
    wlen_24 = 2'h2,
    wlen_32 = 2'h3
  } astx_wlen_t;
endpackage

// >>> design/astx_pair_buf.sv
// small fifo holding sample pairs ahead of the link crossing
`timescale 1ns/1ps
`default_nettype none
module astx_pair_buf #(
  parameter int W = 64,
  parameter int DEPTH = 2
) (
  input wire logic clk, // source clock
  input wire logic rst_n, // async reset, low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // word held
  input wire logic out_ready, // drain accepts
  output logic [W-1:0] out_data // oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != CW'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end
endmodule
`default_nettype wire

// >>> test/astx_host_model.sv
// host side model: bit clock, frame sync and capture of both data wires
`timescale 1ns/1ps
`default_nettype none
module astx_host_model
  import astx_pkg::*;
(
  input wire logic pin_p, // primary wire level
  input wire logic pin_s, // secondary wire level
  output logic bit_clk, // link bit clock
  output logic frame_sync // link frame sync
);
  logic cap_p [0:299];
  logic cap_s [0:299];
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
  end
  // eight lead-in clocks, then nb + 2 bit clocks; clock stands still between frames
  task automatic frame(input logic [1:0] fmt, input int nb);
    for (int n = -8; n < nb + 2; n++) begin
      if (n >= 0) begin
        cap_p[n] = pin_p;
        cap_s[n] = pin_s;
      end
      if (n < 0) frame_sync = (fmt == fmt_i2s);
      else if (fmt == fmt_tdm) frame_sync = (n == 0);
      else if (fmt == fmt_i2s) frame_sync = (n >= 32);
      else frame_sync = (n < 32);
      #3 bit_clk = 1'b1;
      #3 bit_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> test/asi_tx_channel_slot_mapper_test.sv
// self-checking bench for the tx slot mapper
`timescale 1ns/1ps
`default_nettype none
module asi_tx_channel_slot_mapper_test
  import astx_pkg::*;
;
  typedef struct {
    logic [7:0] pin;
    logic [7:0] c1;
    logic [7:0] c2;
    logic [1:0] fmt;
    logic [1:0] wl;
    logic fill;
    int nb;
  } astx_row_t;
  logic ref_clk, resetn, reg_we, reg_re, idle_cycle_fill, smp_valid, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] fmt_sel, slot_word_length;
  logic [31:0] smp_ch1, smp_ch2, s1, s2;
  logic smp_ready, bit_clk, frame_sync, sp, sp_oe_n, ss, ss_oe_n;
  wire logic pin_p, pin_s;
  logic [7:0] cfg [0:2];
  int fails, n_compared, cnt;
  astx_row_t rows [0:7] = '{
    '{8'h00, 8'h20, 8'h21, fmt_tdm, wlen_32, 1'b0, 64},
    '{8'h02, 8'h23, 8'h23, fmt_tdm, wlen_16, 1'b1, 64},
    '{8'hfe, 8'h02, 8'h20, fmt_tdm, wlen_24, 1'b0, 64},
    '{8'ha4, 8'h21, 8'h31, fmt_i2s, wlen_16, 1'b0, 64},
    '{8'h01, 8'h30, 8'h00, fmt_lj, wlen_32, 1'b0, 64},
    '{8'h00, 8'h05, 8'h25, fmt_tdm, wlen_20, 1'b0, 120},
    '{8'h00, 8'h21, 8'h21, fmt_tdm, wlen_32, 1'b1, 64},
    '{8'h5a, 8'h30, 8'h11, fmt_tdm, wlen_16, 1'b0, 290}};
  assign pin_p = sp_oe_n ? 1'bz : sp;
  assign pin_s = ss_oe_n ? 1'bz : ss;
  astx_slot_mapper #(.BUF_DEPTH(2)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_we(reg_we), .reg_re(reg_re), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .fmt_sel(fmt_sel), .slot_word_length(slot_word_length),
    .idle_cycle_fill(idle_cycle_fill), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_ch1(smp_ch1), .smp_ch2(smp_ch2), .bit_clk(bit_clk), .frame_sync(frame_sync),
    .serial_out_primary(sp), .serial_out_primary_oe_n(sp_oe_n),
    .serial_out_secondary(ss), .serial_out_secondary_oe_n(ss_oe_n));
  astx_host_model host_u (.pin_p(pin_p), .pin_s(pin_s), .bit_clk(bit_clk),
    .frame_sync(frame_sync));
  // ****************
  // expected wire level
  // ****************
  function automatic logic hit(input logic [4:0] f, input int k, input int slot);
    if (fmt_sel == fmt_tdm) return slot == f;
    return (f[4] == (k >= 32)) && (slot == f[3:0]);
  endfunction
  function automatic logic exp_bit(input logic sec, input int k);
    int len, pos;
    logic m1, m2;
    len = 16 + 4 * slot_word_length + ((slot_word_length == 2'h3) ? 4 : 0);
    pos = (fmt_sel == fmt_tdm) ? k : k % 32;
    m1 = hit(cfg[1][4:0], k, pos / len) && (cfg[0][0] == sec);
    m2 = hit(cfg[2][4:0], k, pos / len) && (cfg[0][1] == sec);
    if (m1 && cfg[1][5]) return s1[31 - pos % len];
    if (m2 && cfg[2][5]) return s2[31 - pos % len];
    if (m1 || m2 || idle_cycle_fill) return 1'bz;
    return 1'b0;
  endfunction
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 check(reg_rdata, e);
  endtask
  task automatic push(input logic [31:0] a, input logic [31:0] b, output logic acc);
    @(posedge ref_clk);
    smp_valid <= 1'b1;
    smp_ch1 <= a;
    smp_ch2 <= b;
    acc = 1'b0;
    for (int i = 0; i < 4 && !acc; i++) begin
      @(posedge ref_clk);
      acc = (smp_ready === 1'b1);
    end
    smp_valid <= 1'b0;
  endtask
  task automatic run_frame(input int nb);
    host_u.frame(fmt_sel, nb);
    for (int k = 0; k < nb; k++) begin
      check(host_u.cap_p[k + 2], exp_bit(1'b0, k));
      check(host_u.cap_s[k + 2], exp_bit(1'b1, k));
    end
  endtask
  task automatic reset_check;
    @(posedge ref_clk);
    resetn <= 1'b0;
    fmt_sel <= fmt_tdm;
    slot_word_length <= wlen_32;
    idle_cycle_fill <= 1'b1;
    host_u.frame(fmt_tdm, -2);
    repeat (8) @(posedge ref_clk);
    check(smp_ready, 1'b1);
    check({sp_oe_n, ss_oe_n}, 2'h3);
    resetn <= 1'b1;
    cfg = '{8'h00, 8'h20, 8'h21};
    for (int j = 0; j < 3; j++) rd_check(8'(8'h1d + j), cfg[j]);
    s1 = 32'h0;
    s2 = 32'h0;
    run_frame(64);
    $display("reset test done");
  endtask
  task automatic apply(input astx_row_t r, input int i);
    @(posedge ref_clk);
    fmt_sel <= r.fmt;
    slot_word_length <= r.wl;
    idle_cycle_fill <= r.fill;
    cfg = '{r.pin, r.c1, r.c2};
    for (int j = 0; j < 3; j++) wr(8'(8'h1d + j), cfg[j]);
    for (int j = 0; j < 3; j++) rd_check(8'(8'h1d + j), cfg[j]);
    s1 = 32'hc3a5_0f01 + i;
    s2 = 32'h5e17_90f2 ^ i;
    push(s1, s2, ok);
    check(ok, 1'b1);
    run_frame(r.nb);
    $display("row %0d done", i);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    fails++;
    finish_test;
  end
  initial begin
    resetn = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fmt_sel = fmt_tdm;
    slot_word_length = wlen_32;
    idle_cycle_fill = 1'b1;
    smp_valid = 1'b0;
    smp_ch1 = 32'h0;
    smp_ch2 = 32'h0;
    reset_check;
    foreach (rows[i]) apply(rows[i], i);
    wr(8'h1e, 8'hff);
    rd_check(8'h1e, 8'h3f);
    wr(8'h20, 8'h55);
    rd_check(8'h20, 8'h00);
    rd_check(8'h1c, 8'h00);
    $display("refusal test done");
    reset_check;
    // fill the buffer with the link stalled, then drain in order
    cnt = 0;
    ok = 1'b1;
    while (ok && cnt < 4) begin
      push(32'h9c3a_5001 + cnt, 32'h06e1_7702 + cnt, ok);
      cnt += ok;
    end
    check(cnt >= 2, 1'b1);
    check(smp_ready, 1'b0);
    for (int i = 0; i <= cnt; i++) begin
      s1 = 32'h9c3a_5001 + ((i < cnt) ? i : cnt - 1);
      s2 = 32'h06e1_7702 + ((i < cnt) ? i : cnt - 1);
      run_frame(64);
    end
    $display("buffer test done");
    finish_test;
  end
endmodule
`default_nettype wire
